// ==== verilog/cfs_top.sv ====
// Cooling fan supervisor: fan switching, fan fault handling and register port.
//
// Overview of operation
// - Always-on mode turns the fan on as soon as power is present.
// - Always-on mode turns the fan off when the main circuit undervoltage appears.
// - Command mode turns the fan on with power present and run command on.
// - Command mode turns the fan off once run is off and output is shut.
// - Command mode keeps the fan on while the heat sink is over temperature.
// - Continue mode never stops the drive on a fan fault.
// - Continue mode drives the fan alarm on terminals selecting code eighteen.
// - Stop mode stops the drive on a fan fault and shows a fault message.
// - Stop mode signals the fault on terminals selecting code seventeen.
// - Terminal selects accept zero to nineteen, resetting to twelve and seventeen.
`timescale 1ns/10ps
module cfs_top
   import cfs_pkg::*;
(
   input wire logic clk_sys,                      // System clock, 25 MHz.
   input wire logic rst_n,                        // Asynchronous reset, active low.
   input wire logic [cfs_pkg::CFS_AW-1:0] addr,   // Register byte address.
   input wire logic [cfs_pkg::CFS_DW-1:0] wr_data, // Register write data.
   input wire logic wr_en,                        // Write strobe, one cycle.
   input wire logic rd_en,                        // Read strobe, one cycle.
   output logic [cfs_pkg::CFS_DW-1:0] rd_data,    // Read data, cycle after strobe.
   input wire logic run_cmd,                      // Run command pin.
   input wire logic out_active,                   // Drive output active pin.
   input wire logic undervolt,                    // Main circuit undervoltage pin.
   input wire logic over_temp,                    // Heat sink over temperature pin.
   input wire logic fan_trip,                     // Fan fault pin.
   output logic fan_on,                           // Cooling fan drive.
   output logic drive_stop,                       // Stop drive operation on fault.
   output logic fault_msg,                        // Show fan fault message.
   output logic out_terminal,                     // Multi-function output terminal.
   output logic out_relay,                        // Multi-function relay.
   output logic irq                               // Level interrupt.
);
   import cfs_pkg::*;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic [1:0] rst_pipe_r;
   logic rst_sync_n;

   // Reset asserts at once and releases two edges later, clean to the clock.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe_r <= 2'h0;
      end else begin
         rst_pipe_r <= {rst_pipe_r[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_pipe_r[1];

   // ----------------------------------------
   // Sub blocks
   // ----------------------------------------
   cfs_link_if #(.IN_N(CFS_IN_N), .EV_N(CFS_EV_N)) lnk ();

   assign lnk.pin_raw = {fan_trip, over_temp, undervolt, out_active, run_cmd};

   // Every pin passes two flops before the supervisor looks at it.
   cfs_in_sync #(.IN_N(CFS_IN_N)) u_sync (
      .clk_sys(clk_sys),
      .rst_sync_n(rst_sync_n),
      .lnk(lnk.sync_mp)
   );

   cfs_irq #(.EV_N(CFS_EV_N)) u_irq (
      .clk_sys(clk_sys),
      .rst_sync_n(rst_sync_n),
      .lnk(lnk.irq_mp)
   );

   logic run_s;
   logic act_s;
   logic uv_s;
   logic ot_s;
   logic trip_s;

   assign run_s = lnk.pin_sync[CFS_IN_RUN];
   assign act_s = lnk.pin_sync[CFS_IN_OUT_ACT];
   assign uv_s = lnk.pin_sync[CFS_IN_UV];
   assign ot_s = lnk.pin_sync[CFS_IN_OT];
   assign trip_s = lnk.pin_sync[CFS_IN_TRIP];

   // ----------------------------------------
   // Terminal function decode
   // ----------------------------------------
   // Shared by the output terminal and the relay; other codes belong to
   // functions outside this block and leave the pin low here.
   function automatic logic term_drive(
      input logic [CFS_SELW-1:0] sel,
      input logic alarm,
      input logic fault
   );
      logic res;
      res = 1'b0;
      case (sel)
         CFS_FUNC_FAN_ALARM: res = alarm;
         CFS_FUNC_FAULT: res = fault;
         default: res = 1'b0;
      endcase
      return res;
   endfunction

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic fan_mode_r;
   logic fan_mode_nxt;
   logic trip_act_r;
   logic trip_act_nxt;
   logic [CFS_SELW-1:0] out_sel_r;
   logic [CFS_SELW-1:0] out_sel_nxt;
   logic [CFS_SELW-1:0] rly_sel_r;
   logic [CFS_SELW-1:0] rly_sel_nxt;
   logic [CFS_SELW-1:0] wr_sel;
   logic wr_ctrl;
   logic wr_out;
   logic wr_rly;
   logic wr_clr;
   logic wr_stat;
   logic wr_mask;

   assign wr_sel = wr_data[CFS_SELW-1:0];
   assign wr_ctrl = wr_en && (addr == CFS_OFS_CTRL);
   assign wr_out = wr_en && (addr == CFS_OFS_OUT_SEL);
   assign wr_rly = wr_en && (addr == CFS_OFS_RLY_SEL);
   assign wr_clr = wr_en && (addr == CFS_OFS_FAULT_CLR);
   assign wr_stat = wr_en && (addr == CFS_OFS_IRQ_STAT);
   assign wr_mask = wr_en && (addr == CFS_OFS_IRQ_MASK);

   // A select code above the top of the range is dropped and the old code kept.
   always_comb begin
      fan_mode_nxt = fan_mode_r;
      trip_act_nxt = trip_act_r;
      out_sel_nxt = out_sel_r;
      rly_sel_nxt = rly_sel_r;
      if (wr_ctrl) begin
         fan_mode_nxt = wr_data[CFS_CTRL_FAN_MODE_BIT];
         trip_act_nxt = wr_data[CFS_CTRL_TRIP_ACT_BIT];
      end
      if (wr_out && (wr_data[CFS_DW-1:CFS_SELW] == '0) && (wr_sel <= CFS_FUNC_MAX)) begin
         out_sel_nxt = wr_sel;
      end
      if (wr_rly && (wr_data[CFS_DW-1:CFS_SELW] == '0) && (wr_sel <= CFS_FUNC_MAX)) begin
         rly_sel_nxt = wr_sel;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         fan_mode_r <= CFS_CTRL_RST[CFS_CTRL_FAN_MODE_BIT];
         trip_act_r <= CFS_CTRL_RST[CFS_CTRL_TRIP_ACT_BIT];
         out_sel_r <= CFS_OUT_SEL_RST;
         rly_sel_r <= CFS_RLY_SEL_RST;
      end else begin
         fan_mode_r <= fan_mode_nxt;
         trip_act_r <= trip_act_nxt;
         out_sel_r <= out_sel_nxt;
         rly_sel_r <= rly_sel_nxt;
      end
   end

   // ----------------------------------------
   // Fan state machine
   // ----------------------------------------
   cfs_fan_st_t fan_st_r;
   cfs_fan_st_t fan_st_nxt;
   logic fan_go;
   logic fan_stop;

   // Undervoltage means the supply is gone, so it wins in both modes. In
   // command mode the fan only rests with run off, output shut and a cool
   // heat sink; any one of those keeps it turning.
   assign fan_go = !uv_s && ((fan_mode_r == CFS_FAN_ALWAYS) || run_s || ot_s);
   assign fan_stop = uv_s || ((fan_mode_r == CFS_FAN_CMD) && !run_s && !act_s && !ot_s);

   always_comb begin
      fan_st_nxt = fan_st_r;
      case (fan_st_r)
         CFS_FAN_OFF: begin
            if (fan_go) begin
               fan_st_nxt = CFS_FAN_ON;
            end
         end
         CFS_FAN_ON: begin
            if (fan_stop) begin
               fan_st_nxt = CFS_FAN_OFF;
            end
         end
         default: fan_st_nxt = CFS_FAN_OFF;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         fan_st_r <= CFS_FAN_OFF;
      end else begin
         fan_st_r <= fan_st_nxt;
      end
   end

   // ----------------------------------------
   // Fan fault handling
   // ----------------------------------------
   logic alarm_r;
   logic alarm_nxt;
   logic fault_r;
   logic fault_nxt;
   logic out_term_r;
   logic out_term_nxt;
   logic out_rly_r;
   logic out_rly_nxt;

   // In continue mode the alarm follows the trip and the drive runs on; in
   // stop mode the fault latches until software clears it, and a trip that
   // is still present in the clearing cycle keeps it set.
   always_comb begin
      alarm_nxt = (trip_act_r == CFS_TRIP_CONT) && trip_s;
      fault_nxt = fault_r;
      if (wr_clr && wr_data[CFS_CLR_FAULT_BIT]) begin
         fault_nxt = 1'b0;
      end
      if ((trip_act_r == CFS_TRIP_STOP) && trip_s) begin
         fault_nxt = 1'b1;
      end
      out_term_nxt = term_drive(out_sel_r, alarm_r, fault_r);
      out_rly_nxt = term_drive(rly_sel_r, alarm_r, fault_r);
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         alarm_r <= 1'b0;
         fault_r <= 1'b0;
         out_term_r <= 1'b0;
         out_rly_r <= 1'b0;
      end else begin
         alarm_r <= alarm_nxt;
         fault_r <= fault_nxt;
         out_term_r <= out_term_nxt;
         out_rly_r <= out_rly_nxt;
      end
   end

   // ----------------------------------------
   // Interrupt events
   // ----------------------------------------
   logic [CFS_EV_N-1:0] ev_lvl;
   logic [CFS_EV_N-1:0] ev_prev_r;

   // Rising edges of trip, over temperature and undervoltage raise events.
   assign ev_lvl = {uv_s, ot_s, trip_s};

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ev_prev_r <= '0;
      end else begin
         ev_prev_r <= ev_lvl;
      end
   end

   assign lnk.evt = ev_lvl & ~ev_prev_r;
   assign lnk.clr = wr_stat ? wr_data[CFS_EV_N-1:0] : '0;
   assign lnk.mask_we = wr_mask;
   assign lnk.mask_wdata = wr_data[CFS_EV_N-1:0];

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   logic [CFS_DW-1:0] rd_data_r;
   logic [CFS_DW-1:0] rd_data_nxt;
   logic [CFS_DW-1:0] state_word;

   always_comb begin
      state_word = '0;
      state_word[CFS_IN_N-1:0] = lnk.pin_sync;
      state_word[CFS_ST_FAN_BIT] = (fan_st_r == CFS_FAN_ON);
      state_word[CFS_ST_ALARM_BIT] = alarm_r;
      state_word[CFS_ST_FAULT_BIT] = fault_r;
   end

   // Data stands only in the cycle after the strobe; unmapped reads give zero.
   always_comb begin
      rd_data_nxt = '0;
      if (rd_en) begin
         case (addr)
            CFS_OFS_CTRL: begin
               rd_data_nxt[CFS_CTRL_FAN_MODE_BIT] = fan_mode_r;
               rd_data_nxt[CFS_CTRL_TRIP_ACT_BIT] = trip_act_r;
            end
            CFS_OFS_OUT_SEL: rd_data_nxt[CFS_SELW-1:0] = out_sel_r;
            CFS_OFS_RLY_SEL: rd_data_nxt[CFS_SELW-1:0] = rly_sel_r;
            CFS_OFS_STATE: rd_data_nxt = state_word;
            CFS_OFS_IRQ_STAT: rd_data_nxt[CFS_EV_N-1:0] = lnk.stat;
            CFS_OFS_IRQ_MASK: rd_data_nxt[CFS_EV_N-1:0] = lnk.mask;
            default: rd_data_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rd_data_r <= '0;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Every output is a flop, so pins stay quiet through input changes.
   assign rd_data = rd_data_r;
   assign fan_on = (fan_st_r == CFS_FAN_ON);
   assign drive_stop = fault_r;
   assign fault_msg = fault_r;
   assign out_terminal = out_term_r;
   assign out_relay = out_rly_r;
   assign irq = lnk.irq;
endmodule

// ==== pkg/cfs_pkg.sv ====
// Constants and types shared by the cooling fan supervisor files.
package cfs_pkg;
   // ----------------------------------------
   // Bus geometry
   // ----------------------------------------
   localparam int CFS_AW = 8;
   localparam int CFS_DW = 32;
   localparam int CFS_SELW = 5;
   localparam int CFS_SYNC_STAGES = 2;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [CFS_AW-1:0] CFS_OFS_CTRL = 8'h00;
   localparam logic [CFS_AW-1:0] CFS_OFS_OUT_SEL = 8'h04;
   localparam logic [CFS_AW-1:0] CFS_OFS_RLY_SEL = 8'h08;
   localparam logic [CFS_AW-1:0] CFS_OFS_STATE = 8'h0C;
   localparam logic [CFS_AW-1:0] CFS_OFS_IRQ_STAT = 8'h10;
   localparam logic [CFS_AW-1:0] CFS_OFS_IRQ_MASK = 8'h14;
   localparam logic [CFS_AW-1:0] CFS_OFS_FAULT_CLR = 8'h18;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CFS_CTRL_FAN_MODE_BIT = 0;
   localparam int CFS_CTRL_TRIP_ACT_BIT = 1;
   localparam int CFS_CLR_FAULT_BIT = 0;
   localparam int CFS_ST_FAN_BIT = 5;
   localparam int CFS_ST_ALARM_BIT = 6;
   localparam int CFS_ST_FAULT_BIT = 7;
   // Synchronised input lanes.
   localparam int CFS_IN_RUN = 0;
   localparam int CFS_IN_OUT_ACT = 1;
   localparam int CFS_IN_UV = 2;
   localparam int CFS_IN_OT = 3;
   localparam int CFS_IN_TRIP = 4;
   localparam int CFS_IN_N = 5;
   // Interrupt event lanes.
   localparam int CFS_EV_TRIP = 0;
   localparam int CFS_EV_OT = 1;
   localparam int CFS_EV_UV = 2;
   localparam int CFS_EV_N = 3;
   // ----------------------------------------
   // Mode values and function codes
   // ----------------------------------------
   localparam logic CFS_FAN_ALWAYS = 1'b0;
   localparam logic CFS_FAN_CMD = 1'b1;
   localparam logic CFS_TRIP_CONT = 1'b0;
   localparam logic CFS_TRIP_STOP = 1'b1;
   localparam logic [1:0] CFS_CTRL_RST = 2'h0;
   localparam logic [CFS_SELW-1:0] CFS_FUNC_FAULT = 5'h11;
   localparam logic [CFS_SELW-1:0] CFS_FUNC_FAN_ALARM = 5'h12;
   localparam logic [CFS_SELW-1:0] CFS_FUNC_MAX = 5'h13;
   localparam logic [CFS_SELW-1:0] CFS_OUT_SEL_RST = 5'h0C;
   localparam logic [CFS_SELW-1:0] CFS_RLY_SEL_RST = 5'h11;
   // Fan drive state.
   typedef enum logic {
      CFS_FAN_OFF = 1'b0,
      CFS_FAN_ON = 1'b1
   } cfs_fan_st_t;
endpackage

// ==== pkg/cfs_link_if.sv ====
// Interface joining the supervisor top to its synchroniser and interrupt blocks.
`timescale 1ns/10ps
interface cfs_link_if #(
   parameter int IN_N = 5,
   parameter int EV_N = 3
);
   logic [IN_N-1:0] pin_raw;
   logic [IN_N-1:0] pin_sync;
   logic [EV_N-1:0] evt;
   logic [EV_N-1:0] clr;
   logic [EV_N-1:0] mask_wdata;
   logic mask_we;
   logic [EV_N-1:0] stat;
   logic [EV_N-1:0] mask;
   logic irq;
   modport sync_mp (input pin_raw, output pin_sync);
   modport irq_mp (input evt, clr, mask_wdata, mask_we, output stat, mask, irq);
   modport top_mp (output pin_raw, evt, clr, mask_wdata, mask_we,
      input pin_sync, stat, mask, irq);
endinterface

// ==== verilog/cfs_in_sync.sv ====
// Two-stage synchroniser bank for the asynchronous supervisor inputs.
`timescale 1ns/10ps
module cfs_in_sync #(
   parameter int IN_N = 5
) (
   input wire logic clk_sys,        // System clock.
   input wire logic rst_sync_n,     // Synchronised reset, active low.
   cfs_link_if.sync_mp lnk          // Raw pins in, synchronised copy out.
);
   import cfs_pkg::*;

   logic [IN_N-1:0] meta_r;
   logic [IN_N-1:0] sync_r;

   // ----------------------------------------
   // One synchroniser per lane
   // ----------------------------------------
   // The first stage feeds the second stage only, so a metastable value never spreads.
   genvar gi;
   generate
      for (gi = 0; gi < IN_N; gi++) begin : g_lane
         always_ff @(posedge clk_sys or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
               meta_r[gi] <= 1'b0;
               sync_r[gi] <= 1'b0;
            end else begin
               meta_r[gi] <= lnk.pin_raw[gi];
               sync_r[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate

   assign lnk.pin_sync = sync_r;
endmodule

// ==== verilog/cfs_irq.sv ====
// Sticky interrupt status, mask and level interrupt for the supervisor.
`timescale 1ns/10ps
module cfs_irq #(
   parameter int EV_N = 3
) (
   input wire logic clk_sys,        // System clock.
   input wire logic rst_sync_n,     // Synchronised reset, active low.
   cfs_link_if.irq_mp lnk           // Events and clears in, status and irq out.
);
   import cfs_pkg::*;

   logic [EV_N-1:0] stat_r;
   logic [EV_N-1:0] stat_nxt;
   logic [EV_N-1:0] mask_r;
   logic [EV_N-1:0] mask_nxt;
   logic irq_r;
   logic irq_nxt;

   // ----------------------------------------
   // Next values
   // ----------------------------------------
   // A new event in the clearing cycle survives, so no event is lost.
   always_comb begin
      stat_nxt = (stat_r & ~lnk.clr) | lnk.evt;
      mask_nxt = lnk.mask_we ? lnk.mask_wdata : mask_r;
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   // Registered so the interrupt line is glitch free.
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         stat_r <= '0;
         mask_r <= '0;
         irq_r <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign lnk.stat = stat_r;
   assign lnk.mask = mask_r;
   assign lnk.irq = irq_r;
endmodule

// ==== sim/cfs_top_chk.sv ====
// Concurrent checks on the cooling fan supervisor ports, with their bind.
`timescale 1ns/10ps
module cfs_top_chk (
   input wire logic clk_sys,                      // System clock.
   input wire logic rst_n,                        // Reset, active low.
   input wire logic [cfs_pkg::CFS_AW-1:0] addr,   // Register address.
   input wire logic [cfs_pkg::CFS_DW-1:0] wr_data, // Write data.
   input wire logic wr_en,                        // Write strobe.
   input wire logic run_cmd,                      // Run command pin.
   input wire logic out_active,                   // Output active pin.
   input wire logic undervolt,                    // Undervoltage pin.
   input wire logic over_temp,                    // Over temperature pin.
   input wire logic fan_trip,                     // Fan fault pin.
   input wire logic fan_on,                       // Fan drive.
   input wire logic drive_stop,                   // Drive stop.
   input wire logic fault_msg,                    // Fault message.
   input wire logic out_terminal,                 // Output terminal.
   input wire logic out_relay                     // Relay.
);
   import cfs_pkg::*;
   logic [1:0] ctrl_r;
   logic [CFS_SELW-1:0] osel_r;
   logic [CFS_SELW-1:0] rsel_r;
   logic cmd_m;
   logic stop_m;
   // ----------------------------------------
   // Settings mirror
   // ----------------------------------------
   // Over-range select writes are dropped here too, or the mirror would drift.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CFS_CTRL_RST;
         osel_r <= CFS_OUT_SEL_RST;
         rsel_r <= CFS_RLY_SEL_RST;
      end else if (wr_en) begin
         if (addr == CFS_OFS_CTRL) begin
            ctrl_r <= wr_data[1:0];
         end
         if (addr == CFS_OFS_OUT_SEL && wr_data <= 32'h13) begin
            osel_r <= wr_data[CFS_SELW-1:0];
         end
         if (addr == CFS_OFS_RLY_SEL && wr_data <= 32'h13) begin
            rsel_r <= wr_data[CFS_SELW-1:0];
         end
      end
   end
   assign cmd_m = (ctrl_r[CFS_CTRL_FAN_MODE_BIT] == CFS_FAN_CMD);
   assign stop_m = (ctrl_r[CFS_CTRL_TRIP_ACT_BIT] == CFS_TRIP_STOP);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   // Repetition counts leave room for the two sync flops and the decision flop.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_reset_fan_off: assert property ($rose(rst_n) |-> !fan_on)
      else $error("fan on right after reset");
   chk_always_on_fan: assert property ((!cmd_m && !undervolt) [*8] |-> fan_on)
      else $error("fan off in always-on mode");
   chk_uv_fan_off: assert property (undervolt [*5] |-> !fan_on)
      else $error("fan on during undervoltage");
   chk_cmd_run_on: assert property ((cmd_m && run_cmd && !undervolt) [*6] |-> fan_on)
      else $error("fan off with run command");
   chk_cmd_idle_off: assert property ((cmd_m && !run_cmd && !out_active && !over_temp) [*6]
      |-> !fan_on)
      else $error("fan on while idle in command mode");
   chk_hot_fan_on: assert property ((cmd_m && over_temp && !undervolt) [*6] |-> fan_on)
      else $error("fan off while heat sink hot");
   chk_cont_no_stop: assert property ($rose(drive_stop) |-> stop_m)
      else $error("drive stopped in continue mode");
   chk_alarm_term: assert property ((!stop_m && fan_trip && osel_r == CFS_FUNC_FAN_ALARM) [*6]
      |-> out_terminal)
      else $error("fan alarm missing on terminal");
   chk_stop_latch: assert property ((stop_m && fan_trip) [*5] |-> drive_stop)
      else $error("no drive stop on fan fault");
   chk_msg_follows: assert property (fault_msg == drive_stop)
      else $error("fault message differs from drive stop");
   // The stop latch may only drop through a software clear of its bit.
   chk_clear_only: assert property ($fell(drive_stop) |-> $past(wr_en)
      && ($past(addr) == CFS_OFS_FAULT_CLR) && $past(wr_data[CFS_CLR_FAULT_BIT]))
      else $error("fault latch dropped without a clear");
   chk_fault_relay: assert property ((rsel_r == CFS_FUNC_FAULT && drive_stop) [*3]
      |-> out_relay)
      else $error("fault output missing on relay");
endmodule
bind cfs_top cfs_top_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
   .wr_data(wr_data), .wr_en(wr_en), .run_cmd(run_cmd), .out_active(out_active),
   .undervolt(undervolt), .over_temp(over_temp), .fan_trip(fan_trip), .fan_on(fan_on),
   .drive_stop(drive_stop), .fault_msg(fault_msg), .out_terminal(out_terminal),
   .out_relay(out_relay));

// ==== sim/cfs_fan_model.sv ====
// Behavioural model of the cooling fan and the heat sink sensing.
`timescale 1ns/10ps
module cfs_fan_model (
   input wire logic clk_sys, // System clock.
   input wire logic fan_on,  // Fan drive from the supervisor.
   input wire logic heat,    // Heat sink hot, set by the bench.
   input wire logic broken,  // Fan rotor seized, set by the bench.
   output logic over_temp,   // Over temperature sense.
   output logic fan_trip     // Fan fault sense.
);
   // The sensor is a plain comparator, so it follows the heat at once.
   assign over_temp = heat;
   // A seized fan is only noticed while it is being driven.
   always_ff @(posedge clk_sys) begin
      fan_trip <= fan_on & broken;
   end
endmodule

// ==== sim/test_cooling_fan_supervisor.sv ====
// Self-checking testbench for the cooling fan supervisor.
`timescale 1ns/10ps
module test_cooling_fan_supervisor;
   import cfs_pkg::*;
   logic clk_sys, rst_n, wr_en, rd_en, run_cmd, out_active, undervolt, heat, broken;
   logic over_temp, fan_trip, fan_on, drive_stop, fault_msg, out_terminal, out_relay, irq;
   logic [CFS_AW-1:0] addr;
   logic [CFS_DW-1:0] wr_data, rd_data;
   logic fan_prev;
   logic [4:0] corner [7] = '{5'h00, 5'h01, 5'h18, 5'h14, 5'h10, 5'h12, 5'h10};
   int fails, samples_checked, cycles;
   cfs_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .run_cmd(run_cmd),
      .out_active(out_active), .undervolt(undervolt), .over_temp(over_temp),
      .fan_trip(fan_trip), .fan_on(fan_on), .drive_stop(drive_stop), .fault_msg(fault_msg),
      .out_terminal(out_terminal), .out_relay(out_relay), .irq(irq));
   cfs_fan_model fan_u (.clk_sys(clk_sys), .fan_on(fan_on), .heat(heat), .broken(broken),
      .over_temp(over_temp), .fan_trip(fan_trip));
   // ----------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // The whole run needs about 510 cycles, so 5000 means a hang.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   // Strobes drop for one cycle after each access so no signal is set twice at one edge.
   task automatic wr(input logic [CFS_AW-1:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [CFS_AW-1:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      compare(rd_data, exp);
   endtask
   task automatic hold();
      repeat (8) @(posedge clk_sys);
      #1;
   endtask
   function automatic logic fan_exp(input logic mode, input logic run, input logic act,
      input logic hot, input logic uv, input logic prev);
      if (uv) return 1'b0;
      if (mode == CFS_FAN_ALWAYS || run || hot) return 1'b1;
      if (!act) return 1'b0;
      return prev;
   endfunction
   // The new mode acts on the old pins first, so the expectation is chained twice.
   task automatic step(input logic [4:0] c);
      wr(CFS_OFS_CTRL, {31'h0, c[4]});
      fan_prev = fan_exp(c[4], run_cmd, out_active, heat, undervolt, fan_prev);
      fan_prev = fan_exp(c[4], c[3], c[2], c[1], c[0], fan_prev);
      run_cmd <= c[3];
      out_active <= c[2];
      heat <= c[1];
      undervolt <= c[0];
      hold();
      compare(32'(fan_on), 32'(fan_prev));
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst_n, wr_en, rd_en, run_cmd, out_active, undervolt, heat, broken} = 8'h00;
      addr = '0;
      wr_data = '0;
      fan_prev = 1'b0;
      void'($urandom(92));
      repeat (3) @(posedge clk_sys);
      #1;
      compare(32'(fan_on), 32'h0);
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rd(CFS_OFS_CTRL, 32'h0);
      rd(CFS_OFS_OUT_SEL, 32'h0C);
      rd(CFS_OFS_RLY_SEL, 32'h11);
      rd(CFS_OFS_IRQ_MASK, 32'h0);
      rd(8'h1C, 32'h0);
      wr(CFS_OFS_OUT_SEL, 32'h14);
      rd(CFS_OFS_OUT_SEL, 32'h0C);
      wr(CFS_OFS_OUT_SEL, 32'h13);
      rd(CFS_OFS_OUT_SEL, 32'h13);
      wr(CFS_OFS_OUT_SEL, 32'h0);
      rd(CFS_OFS_OUT_SEL, 32'h0);
      foreach (corner[i]) step(corner[i]);
      repeat (30) step(5'($urandom));
      step(5'h00);
      // Continue mode: alarm on the terminal, no stop, relay quiet.
      wr(CFS_OFS_OUT_SEL, 32'h12);
      broken <= 1'b1;
      hold();
      compare(32'(out_terminal), 32'h1);
      compare(32'(drive_stop), 32'h0);
      compare(32'(out_relay), 32'h0);
      @(posedge clk_sys);
      broken <= 1'b0;
      hold();
      compare(32'(out_terminal), 32'h0);
      // Stop mode: the fault latches until it is cleared.
      wr(CFS_OFS_CTRL, 32'h2);
      broken <= 1'b1;
      hold();
      compare(32'(drive_stop), 32'h1);
      compare(32'(fault_msg), 32'h1);
      compare(32'(out_relay), 32'h1);
      rd(CFS_OFS_STATE, 32'hB0);
      @(posedge clk_sys);
      broken <= 1'b0;
      hold();
      compare(32'(drive_stop), 32'h1);
      wr(CFS_OFS_FAULT_CLR, 32'h1);
      hold();
      compare(32'(drive_stop), 32'h0);
      compare(32'(out_relay), 32'h0);
      // Interrupt: raise, mask, unmask and clear the fan trip event.
      wr(CFS_OFS_CTRL, 32'h0);
      wr(CFS_OFS_IRQ_STAT, 32'h7);
      rd(CFS_OFS_IRQ_STAT, 32'h0);
      wr(CFS_OFS_IRQ_MASK, 32'h1);
      broken <= 1'b1;
      hold();
      compare(32'(irq), 32'h1);
      rd(CFS_OFS_IRQ_STAT, 32'h1);
      wr(CFS_OFS_IRQ_MASK, 32'h0);
      hold();
      compare(32'(irq), 32'h0);
      wr(CFS_OFS_IRQ_MASK, 32'h1);
      broken <= 1'b0;
      hold();
      compare(32'(irq), 32'h1);
      wr(CFS_OFS_IRQ_STAT, 32'h1);
      hold();
      compare(32'(irq), 32'h0);
      test_done();
   end
endmodule
